/* rtl/vsi_map.svh */
// Register map, field positions, reset values and timing counts of the angle-jump stage
`ifndef VSI_MAP_SVH
`define VSI_MAP_SVH
// Timing
`define VSI_CLK_HZ 10000000
`define VSI_HIST_MS 40
`define VSI_HIST_DEPTH 8
`define VSI_SAMPLE_CYC (((`VSI_CLK_HZ) / 1000) * (`VSI_HIST_MS) / (`VSI_HIST_DEPTH))
`define VSI_STEP_MS 10
`define VSI_SAMPLES_PER_STEP (((`VSI_STEP_MS) * (`VSI_HIST_DEPTH)) / (`VSI_HIST_MS))
// Unit scaling
`define VSI_BAM_PER_DEG 16'h00B6
`define VSI_CENTI_PER_HZ 17'h00064
`define VSI_DECI_PER_PCT 12'h00A
// Byte offsets
`define VSI_OFF_CTRL 8'h00
`define VSI_OFF_CFG 8'h04
`define VSI_OFF_RATED 8'h08
`define VSI_OFF_BMASK 8'h0C
`define VSI_OFF_STATUS 8'h10
`define VSI_OFF_ISTAT 8'h14
`define VSI_OFF_IMASK 8'h18
`define VSI_OFF_GRP_BASE 3'h1
// Fields
`define VSI_CTRL_EN 0
`define VSI_CTRL_GRP 1
`define VSI_CFG_FIXED 3
`define VSI_GA_THR 0
`define VSI_GA_FWIN 8
`define VSI_GA_VLO 16
`define VSI_GA_VHI 24
`define VSI_GB_DLY 0
`define VSI_GB_PLS 16
// Reset values
`define VSI_DEF_THR 8'h0A
`define VSI_DEF_FWIN 8'h03
`define VSI_DEF_VLO 8'h5A
`define VSI_DEF_VHI 8'h6E
`define VSI_DEF_DLY 16'h0014
`define VSI_DEF_PLS 16'h0014
`define VSI_DEF_RATED 16'h1388
`define VSI_GA_RST {`VSI_DEF_VHI, `VSI_DEF_VLO, `VSI_DEF_FWIN, `VSI_DEF_THR}
`define VSI_GB_RST {`VSI_DEF_PLS, `VSI_DEF_DLY}
`endif

/* rtl/vsi_pkg.sv */
// Types of the angle-jump stage
package vsi_pkg;
  typedef enum logic [1:0] {
    VSI_IDLE = 2'h0,
    VSI_PICK = 2'h1,
    VSI_TRIP = 2'h3
  } vsi_state_t;

  typedef enum logic [2:0] {
    MM_TLN = 3'h0,
    MM_TLN_LNY = 3'h1,
    MM_TLN_LLY = 3'h2,
    MM_TLN_RES = 3'h3,
    MM_TLLR = 3'h4,
    MM_TLLR_LNY = 3'h5,
    MM_TLLR_LLY = 3'h6,
    MM_NONE = 3'h7
  } vsi_meas_mode_t;

  typedef struct packed {
    vsi_state_t st;
    logic [12:0] tmr;
    logic [15:0] div;
    logic [1:0] sub;
    logic en;
    logic [1:0] grp;
    vsi_meas_mode_t mode;
    logic fixed;
    logic [15:0] rated;
    logic [7:0] bmask;
    logic [3:0][31:0] ga;
    logic [3:0][31:0] gb;
    logic [2:0] ists;
    logic [2:0] imask;
    logic ack;
    logic [31:0] dat;
    logic pick;
    logic op;
  } vsi_main_t;

  typedef struct packed {
    logic [7:0][15:0] hist;
    logic [2:0] ptr;
    logic full;
    logic [15:0] delta;
  } vsi_delta_t;
endpackage

/* rtl/vsi_angle_if.sv */
// Sample strobe, angle and angle change between the stage and its history unit
`timescale 1ns/1ps
`default_nettype none
interface vsi_angle_if;
  logic tick;
  logic [15:0] angle;
  logic [15:0] delta;
  modport src (output tick, output angle, input delta);
  modport sink (input tick, input angle, output delta);
endinterface
`default_nettype wire

/* rtl/vsi_angle_delta.sv */
// Angle history over the comparison span and absolute angle change
`timescale 1ns/1ps
`default_nettype none
module vsi_angle_delta
  import vsi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Angle samples in, change out
  vsi_angle_if.sink a
);
  vsi_delta_t s_q;
  vsi_delta_t s_d;
  logic [15:0] diff;

  // Binary angle: modular subtraction wraps through 360 degrees for free
  always_comb
  begin
    s_d = s_q;
    diff = a.angle - s_q.hist[s_q.ptr];
    if (a.tick)
    begin
      s_d.hist[s_q.ptr] = a.angle;
      s_d.ptr = s_q.ptr + 3'h1;
      s_d.full = s_q.full || (s_q.ptr == 3'h7);
      // Empty history would look like a huge jump, so report none
      s_d.delta = s_q.full ? (diff[15] ? 16'(-diff) : diff) : 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign a.delta = s_q.delta;

  a_delta_empty: assert property (@(posedge clk) disable iff (rst)
    !s_q.full |-> a.delta == 16'h0000) else $error("angle change before history filled");
  a_delta_range: assert property (@(posedge clk) disable iff (rst)
    a.delta <= 16'h8000) else $error("angle change above half turn");
endmodule
`default_nettype wire

/* rtl/vsi_stage.sv */
// Angle-jump islanding stage with Wishbone register file
`timescale 1ns/1ps
`default_nettype none
`include "vsi_map.svh"
// Overview of operation
// - Common enable, off at reset, silences pickup and operate outputs
// - Active only for allowed modes and fixed adaptation
// - Angle change versus angle 40 ms earlier
// - Pickup when change exceeds group threshold
// - Pickup latched; operate after operate delay
// - Voltage, frequency or block cancels delay
// - Block fully resets the latched state
// - Frequency outside rated plus/minus window blocks
// - Rated frequency is the fixed RATED register setting
// - Voltage outside low/high limits blocks
// - Block from masked flags of other stages
module vsi_stage
  import vsi_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `VSI_SAMPLE_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Measurement path
  input wire logic [15:0] seq_angle,
  input wire logic [15:0] meas_freq,
  input wire logic [11:0] positive_seq_voltage,
  input wire logic [7:0] stage_flags,
  // Stage outputs
  output logic angle_jump_pickup,
  output logic angle_jump_operate,
  output logic irq
);
  vsi_main_t s_q;
  vsi_main_t s_d;
  vsi_angle_if ang_if ();

  logic sample_tick;
  logic step_tick;
  logic avail;
  logic blk;
  logic freq_out;
  logic volt_out;
  logic inhibit;
  logic hit;
  logic hit_rst;
  logic wb_req;
  logic wr_go;
  logic [31:0] ga;
  logic [31:0] gb;
  logic [7:0] thr;
  logic [7:0] fwin;
  logic [7:0] vlo;
  logic [7:0] vhi;
  logic [12:0] dly;
  logic [12:0] pls;
  logic [16:0] fw;
  logic [31:0] wmask;
  logic [31:0] rd;
  logic [1:0] wg;
  logic [2:0] ev;

  // Sample divider: eight samples across the comparison span
  assign sample_tick = (s_q.div == 16'(SAMPLE_CYCLES - 1));
  assign step_tick = sample_tick && (s_q.sub == 2'(`VSI_SAMPLES_PER_STEP - 1));

  assign ang_if.tick = sample_tick;
  assign ang_if.angle = seq_angle;

  vsi_angle_delta vsi_angle_delta_i (
    .clk(clk),
    .rst(rst),
    .a(ang_if)
  );

  // Active group feeds every comparison
  assign ga = s_q.ga[s_q.grp];
  assign gb = s_q.gb[s_q.grp];
  assign thr = ga[`VSI_GA_THR +: 8];
  assign fwin = ga[`VSI_GA_FWIN +: 8];
  assign vlo = ga[`VSI_GA_VLO +: 8];
  assign vhi = ga[`VSI_GA_VHI +: 8];
  assign dly = gb[`VSI_GB_DLY +: 13];
  assign pls = gb[`VSI_GB_PLS +: 13];

  assign avail = s_q.fixed && (s_q.mode != MM_NONE);
  assign blk = |(stage_flags & s_q.bmask);
  assign fw = 17'(fwin) * `VSI_CENTI_PER_HZ;
  // Sums kept one bit wider so a large window cannot wrap
  assign freq_out = ({1'b0, meas_freq} + fw < {1'b0, s_q.rated})
    || ({1'b0, meas_freq} > {1'b0, s_q.rated} + fw);
  assign volt_out = (positive_seq_voltage < 12'(vlo) * `VSI_DECI_PER_PCT)
    || (positive_seq_voltage > 12'(vhi) * `VSI_DECI_PER_PCT);
  assign inhibit = blk || freq_out || volt_out;
  assign hit = ang_if.delta > 16'(thr) * `VSI_BAM_PER_DEG;

  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wr_go = wb_req && s_q.ack && wb_we_i;
  assign wg = wb_adr_i[4:3];

  // Byte lanes to bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  always_comb
  begin
    rd = 32'h0000_0000;
    if (wb_adr_i[7:5] == `VSI_OFF_GRP_BASE)
      rd = wb_adr_i[2] ? s_q.gb[wg] : s_q.ga[wg];
    else
    begin
      case (wb_adr_i)
        `VSI_OFF_CTRL: rd = {29'h0, s_q.grp, s_q.en};
        `VSI_OFF_CFG: rd = {28'h0, s_q.fixed, s_q.mode};
        `VSI_OFF_RATED: rd = {16'h0000, s_q.rated};
        `VSI_OFF_BMASK: rd = {24'h0, s_q.bmask};
        `VSI_OFF_STATUS: rd = {ang_if.delta, 10'h0, blk, volt_out, freq_out, avail,
          s_q.op, s_q.pick};
        `VSI_OFF_ISTAT: rd = {29'h0, s_q.ists};
        `VSI_OFF_IMASK: rd = {29'h0, s_q.imask};
        default: rd = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    s_d = s_q;
    hit_rst = 1'b0;
    s_d.div = sample_tick ? 16'h0000 : s_q.div + 16'h0001;
    if (sample_tick)
      s_d.sub = step_tick ? 2'h0 : s_q.sub + 2'h1;

    case (s_q.st)
      VSI_IDLE:
      begin
        if (hit && !inhibit)
        begin
          s_d.st = VSI_PICK;
          s_d.tmr = 13'h0000;
        end
      end
      VSI_PICK:
      begin
        // Jump is a one-shot event, so pickup holds without it
        if (inhibit)
        begin
          s_d.st = VSI_IDLE;
          hit_rst = 1'b1;
        end
        else if (step_tick)
        begin
          if (s_q.tmr + 13'h0001 >= dly)
          begin
            s_d.st = VSI_TRIP;
            s_d.tmr = 13'h0000;
          end
          else
            s_d.tmr = s_q.tmr + 13'h0001;
        end
      end
      VSI_TRIP:
      begin
        if (blk)
        begin
          s_d.st = VSI_IDLE;
          hit_rst = 1'b1;
        end
        else if (step_tick)
        begin
          if (s_q.tmr + 13'h0001 >= pls)
            s_d.st = VSI_IDLE;
          else
            s_d.tmr = s_q.tmr + 13'h0001;
        end
      end
      default: s_d.st = VSI_IDLE;
    endcase
    if (!s_q.en || !avail)
      s_d.st = VSI_IDLE;
    s_d.pick = (s_d.st != VSI_IDLE);
    s_d.op = (s_d.st == VSI_TRIP);

    // Register bus: one wait state; a write lands at the edge where the master sees ack
    s_d.ack = wb_req && !s_q.ack;
    if (wb_req && !s_q.ack)
      s_d.dat = rd;
    if (wr_go)
    begin
      if (wb_adr_i[7:5] == `VSI_OFF_GRP_BASE)
      begin
        if (wb_adr_i[2])
          s_d.gb[wg] = (s_q.gb[wg] & ~wmask) | (wb_dat_i & wmask);
        else
          s_d.ga[wg] = (s_q.ga[wg] & ~wmask) | (wb_dat_i & wmask);
      end
      else
      begin
        case (wb_adr_i)
          `VSI_OFF_CTRL:
          begin
            if (wb_sel_i[0])
            begin
              s_d.en = wb_dat_i[`VSI_CTRL_EN];
              s_d.grp = wb_dat_i[`VSI_CTRL_GRP +: 2];
            end
          end
          `VSI_OFF_CFG:
          begin
            if (wb_sel_i[0])
            begin
              s_d.mode = vsi_meas_mode_t'(wb_dat_i[2:0]);
              s_d.fixed = wb_dat_i[`VSI_CFG_FIXED];
            end
          end
          `VSI_OFF_RATED: s_d.rated = (s_q.rated & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
          `VSI_OFF_BMASK: s_d.bmask = (s_q.bmask & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
          `VSI_OFF_ISTAT: s_d.ists = s_q.ists & ~(wb_dat_i[2:0] & wmask[2:0]);
          `VSI_OFF_IMASK: s_d.imask = (s_q.imask & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
          default: s_d.ists = s_d.ists;
        endcase
      end
    end
    // Applied after the clear so a same-cycle event is kept
    ev = {hit_rst, s_d.op && !s_q.op, s_d.pick && !s_q.pick};
    s_d.ists = s_d.ists | ev;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.ga <= {4{`VSI_GA_RST}};
      s_q.gb <= {4{`VSI_GB_RST}};
      s_q.rated <= `VSI_DEF_RATED;
      s_q.fixed <= 1'b1;
      s_q.mode <= MM_TLN;
    end
    else
      s_q <= s_d;
  end

  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign angle_jump_pickup = s_q.pick;
  assign angle_jump_operate = s_q.op;
  assign irq = |(s_q.ists & s_q.imask);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_off_quiet: assert property (!s_q.en |=> !angle_jump_pickup && !angle_jump_operate)
    else $error("output while stage disabled");
  a_hidden_quiet: assert property (!avail |=> !angle_jump_pickup)
    else $error("pickup while stage unavailable");
  a_pickup_cause: assert property ($rose(angle_jump_pickup) |-> $past(hit && !inhibit))
    else $error("pickup without angle jump");
  a_pickup_held: assert property (s_q.st == VSI_PICK && s_q.en && avail && !inhibit
    && !step_tick |=> s_q.st == VSI_PICK)
    else $error("latched pickup dropped");
  a_trip_order: assert property ($rose(angle_jump_operate) |-> $past(s_q.st == VSI_PICK
    && step_tick && s_q.tmr + 13'h0001 >= dly))
    else $error("operate before delay expiry");
  a_inhibit_clear: assert property (s_q.st == VSI_PICK && inhibit
    |=> !angle_jump_pickup ##1 !angle_jump_operate)
    else $error("inhibit did not cancel delay");
  a_block_reset: assert property (blk && s_q.st != VSI_IDLE |=> s_q.st == VSI_IDLE)
    else $error("block did not reset stage");
  a_freq_block: assert property (freq_out && s_q.st == VSI_IDLE |=> !angle_jump_pickup)
    else $error("pickup outside frequency window");
  a_volt_block: assert property (volt_out && s_q.st == VSI_IDLE |=> !angle_jump_pickup)
    else $error("pickup outside voltage limits");
  a_pulse_end: assert property (s_q.st == VSI_TRIP && !blk && s_q.en && avail && step_tick
    && s_q.tmr + 13'h0001 >= pls |=> !angle_jump_operate && !angle_jump_pickup)
    else $error("operate pulse overran");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  c_pickup: cover property ($rose(angle_jump_pickup));
  c_operate: cover property ($rose(angle_jump_operate));
  c_cancel: cover property (s_q.st == VSI_PICK && inhibit);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* sim/vsi_meas_model.sv */
// Measurement path model feeding angle, frequency and voltage to the stage
`timescale 1ns/1ps
`default_nettype none
module vsi_meas_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench
  input wire logic jump_req,
  input wire logic [15:0] jump_amt,
  input wire logic [15:0] freq_set,
  input wire logic [11:0] volt_set,
  // Measurement outputs
  output logic [15:0] seq_angle,
  output logic [15:0] meas_freq,
  output logic [11:0] positive_seq_voltage
);
  // Angle moves only on command, so a jump is one clean step
  always_ff @(posedge clk or posedge rst)
    if (rst)
      seq_angle <= 16'h0000;
    else if (jump_req)
      seq_angle <= seq_angle + jump_amt;
  assign meas_freq = freq_set;
  assign positive_seq_voltage = volt_set;
endmodule
`default_nettype wire

/* sim/test_vector_shift_islanding_stage.sv */
// Self-checking bench of the angle-jump stage
`timescale 1ns/1ps
`default_nettype none
`include "vsi_map.svh"
module test_vector_shift_islanding_stage;
  logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, jump_req, ok;
  logic angle_jump_pickup, angle_jump_operate, irq;
  logic [7:0] wb_adr_i, stage_flags;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, mon_mask;
  logic [15:0] jump_amt, freq_set, seq_angle, meas_freq;
  logic [11:0] volt_set, positive_seq_voltage;
  logic [31:0] exp_q[$], mask_q[$];
  int pls_q[$];
  int bad_count, total_checks, seed, w, m, g, op_len;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;

  vsi_stage #(.SAMPLE_CYCLES(8)) vsi_stage_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .seq_angle(seq_angle),
    .meas_freq(meas_freq), .positive_seq_voltage(positive_seq_voltage),
    .stage_flags(stage_flags), .angle_jump_pickup(angle_jump_pickup),
    .angle_jump_operate(angle_jump_operate), .irq(irq));
  vsi_meas_model vsi_meas_model_i (.clk(clk), .rst(rst), .jump_req(jump_req),
    .jump_amt(jump_amt), .freq_set(freq_set), .volt_set(volt_set), .seq_angle(seq_angle),
    .meas_freq(meas_freq), .positive_seq_voltage(positive_seq_voltage));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task say(input string s);
    $display("test %s done", s);
  endtask

  // Classic cycle: request held until ack is sampled high
  task wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w_en;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    check(n < 50, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk);
    exp_q.push_back(e);
    mask_q.push_back(msk);
    wb(1'b0, a, 32'h0);
  endtask

  // Read data is judged where ack is sampled
  always @(posedge clk)
  begin
    if (wb_cyc_i && !wb_we_i && wb_ack_o === 1'b1 && exp_q.size() > 0)
    begin
      mon_mask = mask_q.pop_front();
      check(wb_dat_o & mon_mask, exp_q.pop_front() & mon_mask);
    end
  end

  // Operate pulse length judged as the pulse ends
  always @(posedge clk)
  begin
    if (angle_jump_operate === 1'b1)
      op_len++;
    else
    begin
      if (op_len > 0 && pls_q.size() > 0)
        check(op_len, pls_q.pop_front());
      op_len = 0;
    end
  end

  task await(input bit use_op, input logic lvl, input int lim, output logic hit);
    int n;
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++)
    begin
      @(posedge clk);
      hit = ((use_op ? angle_jump_operate : angle_jump_pickup) === lvl);
    end
  endtask

  task jump(input logic [15:0] amt);
    jump_amt <= amt;
    jump_req <= 1'b1;
    @(posedge clk);
    jump_req <= 1'b0;
  endtask

  // Long settle lets the pulse end and the history forget the jump
  task run_jump(input logic [15:0] amt, input logic exp);
    jump(amt);
    await(1'b0, 1'b1, 40, ok);
    check(ok, exp);
    repeat (160) @(posedge clk);
  endtask

  function logic [15:0] rj();
    return 16'd1821 + 16'($random(seed) & 32'h0FFF);
  endfunction

  initial
  begin
    seed = 32'h1B9D;
    bad_count = 0;
    total_checks = 0;
    op_len = 0;
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, jump_req} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    jump_amt = 16'h0000;
    freq_set = 16'h1388;
    volt_set = 12'h3E8;
    stage_flags = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (100) @(posedge clk);
    stage_flags <= 8'($random(seed)) & 8'hFE;
    rd(`VSI_OFF_CTRL, 32'h0, ALL);
    rd(`VSI_OFF_CFG, 32'h8, ALL);
    rd(`VSI_OFF_RATED, 32'h1388, ALL);
    rd(`VSI_OFF_BMASK, 32'h0, ALL);
    rd(`VSI_OFF_STATUS, 32'h4, 32'h7);
    rd(`VSI_OFF_IMASK, 32'h0, ALL);
    for (g = 0; g < 4; g++)
    begin
      rd(8'h20 + 8'(g * 8), `VSI_GA_RST, ALL);
      rd(8'h24 + 8'(g * 8), `VSI_GB_RST, ALL);
    end
    rd(8'hFC, 32'h0, ALL);
    say("reset values");
    run_jump(rj(), 1'b0);
    wb(1'b1, `VSI_OFF_CTRL, 32'h1);
    wb(1'b1, 8'h24, 32'h00020002);
    run_jump(16'(`VSI_BAM_PER_DEG * 16'd10), 1'b0);
    run_jump(16'(`VSI_BAM_PER_DEG * 16'd10 + 16'd1), 1'b1);
    say("threshold");
    // Two pulse steps of two samples of eight cycles each
    pls_q.push_back(2 * `VSI_SAMPLES_PER_STEP * 8);
    jump(16'h0800);
    await(1'b0, 1'b1, 40, ok);
    check(ok, 1'b1);
    rd(`VSI_OFF_STATUS, 32'h08000001, 32'hFFFF0001);
    await(1'b1, 1'b1, 60, ok);
    check({ok, angle_jump_pickup}, 2'b11);
    await(1'b1, 1'b0, 60, ok);
    check({ok, angle_jump_pickup}, 2'b10);
    repeat (80) @(posedge clk);
    rd(`VSI_OFF_STATUS, 32'h0, 32'hFFFF0003);
    check(irq, 1'b0);
    rd(`VSI_OFF_ISTAT, 32'h3, 32'h7);
    wb(1'b1, `VSI_OFF_IMASK, 32'h1);
    check(irq, 1'b1);
    wb(1'b1, `VSI_OFF_ISTAT, 32'h7);
    check(irq, 1'b0);
    rd(`VSI_OFF_ISTAT, 32'h0, 32'h7);
    say("operate pulse and irq");
    for (w = 1; w <= 5; w++)
    begin
      wb(1'b1, 8'h20, {8'h6E, 8'h5A, 8'(w), 8'h0A});
      freq_set <= 16'h1388 + 16'(w * 100) + 16'd1;
      run_jump(rj(), 1'b0);
      freq_set <= 16'h1388 - 16'(w * 100);
      run_jump(rj(), 1'b1);
    end
    wb(1'b1, 8'h20, `VSI_GA_RST);
    wb(1'b1, `VSI_OFF_RATED, 32'h1770);
    freq_set <= 16'h1770;
    run_jump(rj(), 1'b1);
    freq_set <= 16'h1388;
    run_jump(rj(), 1'b0);
    wb(1'b1, `VSI_OFF_RATED, 32'h1388);
    say("frequency");
    volt_set <= 12'd899;
    run_jump(rj(), 1'b0);
    volt_set <= 12'd900;
    run_jump(rj(), 1'b1);
    volt_set <= 12'd1101;
    run_jump(rj(), 1'b0);
    volt_set <= 12'd1100;
    run_jump(rj(), 1'b1);
    volt_set <= 12'h3E8;
    say("voltage");
    for (m = 0; m < 8; m++)
    begin
      wb(1'b1, `VSI_OFF_CFG, {28'h0, 1'b1, 3'(m)});
      run_jump(rj(), m != 7);
    end
    wb(1'b1, `VSI_OFF_CFG, 32'h0);
    run_jump(rj(), 1'b0);
    wb(1'b1, `VSI_OFF_CFG, 32'h8);
    wb(1'b1, 8'h28, 32'h6E5A031E);
    wb(1'b1, `VSI_OFF_CTRL, 32'h3);
    run_jump(16'd3640, 1'b0);
    wb(1'b1, `VSI_OFF_CTRL, 32'h1);
    run_jump(16'd3640, 1'b1);
    say("modes and groups");
    // Long delay keeps the stage waiting while resets are tried
    wb(1'b1, 8'h24, 32'h00020014);
    wb(1'b1, `VSI_OFF_BMASK, 32'h1);
    jump(rj());
    await(1'b0, 1'b1, 40, ok);
    stage_flags <= stage_flags | 8'h01;
    await(1'b0, 1'b0, 4, ok);
    check(ok, 1'b1);
    rd(`VSI_OFF_ISTAT, 32'h4, 32'h4);
    run_jump(rj(), 1'b0);
    stage_flags <= stage_flags & 8'hFE;
    jump(rj());
    await(1'b0, 1'b1, 40, ok);
    volt_set <= 12'd800;
    await(1'b0, 1'b0, 4, ok);
    check(ok, 1'b1);
    repeat (80) @(posedge clk);
    volt_set <= 12'h3E8;
    jump(rj());
    await(1'b0, 1'b1, 40, ok);
    wb(1'b1, `VSI_OFF_CTRL, 32'h0);
    // Disable lands at the ack edge and clears the state one edge later
    @(posedge clk);
    check(angle_jump_pickup, 1'b0);
    say("block and cancel");
    repeat (10) @(posedge clk);
    check(exp_q.size() + pls_q.size(), 0);
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("BAD t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
